// *** rtl/dma_pkg.sv ***
package dma_pkg;
    // descriptor layout in host memory: four words, one after another
    localparam int DESC_WORDS = 4;
    localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
    localparam logic [1:0] DESC_W_CTRL = 2'h0;
    localparam logic [1:0] DESC_W_SRC = 2'h1;
    localparam logic [1:0] DESC_W_DST = 2'h2;
    localparam logic [1:0] DESC_W_LAST = 2'h3;
    // control word fields
    localparam int CTRL_DIR_BIT = 31;
    localparam int CTRL_SIZE_MSB = 17;
    localparam int CTRL_SIZE_LSB = 2;
    localparam logic CTRL_DIR_TO_HOST = 1'b1;
    // byte step between words
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_FETCH_REQ = 3'b001,
        ST_FETCH_WAIT = 3'b010,
        ST_LOAD = 3'b011,
        ST_XFER_REQ = 3'b100,
        ST_XFER_WAIT = 3'b101,
        ST_NEXT = 3'b110,
        ST_IRQ = 3'b111
    } dma_state_t;
endpackage

// *** rtl/descriptor_dma.sv ***
`timescale 1ns/10ps
// Contract
// - write engine copies local memory to host
// - read engine copies host memory to local
// - descriptor holds size, source, destination, control
// - control holds descriptor count, first address
// - engine fetches descriptors without further host accesses
// - each descriptor's transfer is carried out
// - only word-aligned addresses and sizes
// - no end-to-end digest forwarded
// - interrupt requested through control access port
// - outgoing requests go through transmit slave
// - local memory has separate port per engine
// - host target accesses bypass the engines
// - target path counts traffic, acknowledges messages
// - interrupt raised after last descriptor finishes
module descriptor_dma #(
    parameter int MEM_AW = 10
) (
    input wire logic clk_in, // 40 MHz clock
    input wire logic rst_in, // async reset, high
    input wire logic ctrl_load_in, // control register programmed, pulse
    input wire logic [15:0] ctrl_count_in, // descriptors to process
    input wire logic [31:0] ctrl_first_addr_in, // host address of first descriptor
    output logic busy_out, // engine working
    output logic done_out, // last set finished
    output logic tx_valid_out, // request to transmit slave
    output logic tx_write_out, // 1 write, 0 read
    output logic [31:0] tx_addr_out, // host byte address
    output logic [31:0] tx_data_out, // write data
    output logic tx_digest_out, // end-to-end digest request
    input wire logic tx_ready_in, // transmit slave accepts
    input wire logic cpl_valid_in, // read completion word
    input wire logic [31:0] cpl_data_in, // completion data
    input wire logic tgt_valid_in, // host target access
    input wire logic tgt_write_in, // target write
    input wire logic [MEM_AW-1:0] tgt_addr_in, // target word index
    input wire logic [31:0] tgt_wdata_in, // target write data
    output logic tgt_rvalid_out, // target read data valid
    output logic [31:0] tgt_rdata_out, // target read data
    input wire logic msg_valid_in, // incoming message packet
    output logic msg_ack_out, // message acknowledge
    output logic [31:0] perf_count_out, // words moved by target and engines
    input wire logic cfg_msi_enable_in, // sideband: interrupts allowed
    output logic msi_req_out, // interrupt request to control access port
    input wire logic msi_ack_in // interrupt accepted
);
    import dma_pkg::*;

    logic [31:0] mem_r [2**MEM_AW];
    dma_state_t state_r;
    dma_state_t state_nxt;
    logic [15:0] remain_r;
    logic [31:0] desc_addr_r;
    logic [1:0] word_r;
    logic dir_r;
    logic [15:0] size_r;
    logic [31:0] src_r;
    logic [31:0] dst_r;
    logic [31:0] wdata_r;
    logic done_r;
    logic msi_r;
    logic tgt_rvalid_r;
    logic [31:0] tgt_rdata_r;
    logic msg_ack_r;
    logic [31:0] perf_r;

    wire tx_take = tx_valid_out & tx_ready_in;
    wire fetch_req = state_r == ST_FETCH_REQ;
    wire xfer_req = state_r == ST_XFER_REQ;
    wire to_host = dir_r == CTRL_DIR_TO_HOST;
    wire [31:0] fetch_addr = desc_addr_r + {28'h0000000, word_r, 2'b00};
    wire [31:0] src_word = {src_r[31:2], 2'b00};
    wire [31:0] dst_word = {dst_r[31:2], 2'b00};
    wire [MEM_AW-1:0] wr_eng_idx = src_word[MEM_AW+1:2];
    wire [MEM_AW-1:0] rd_eng_idx = dst_word[MEM_AW+1:2];
    wire [15:0] cpl_size = cpl_data_in[CTRL_SIZE_MSB:CTRL_SIZE_LSB];
    wire cpl_fetch = state_r == ST_FETCH_WAIT && cpl_valid_in;
    wire cpl_xfer = state_r == ST_XFER_WAIT && cpl_valid_in;
    wire mem_from_host = cpl_xfer;
    wire tgt_wr = tgt_valid_in & tgt_write_in;
    wire tgt_rd = tgt_valid_in & ~tgt_write_in;
    wire eng_word = (xfer_req & tx_take & to_host) | cpl_xfer;
    wire last_desc = remain_r == 16'h0001;

    // requests leave through the transmit slave
    assign tx_valid_out = fetch_req | xfer_req;
    assign tx_write_out = xfer_req & to_host;
    assign tx_addr_out = fetch_req ? fetch_addr : (to_host ? dst_word : src_word);
    assign tx_data_out = wdata_r;
    assign tx_digest_out = 1'b0;
    assign busy_out = state_r != ST_IDLE;
    assign done_out = done_r;
    assign msi_req_out = msi_r;
    assign tgt_rvalid_out = tgt_rvalid_r;
    assign tgt_rdata_out = tgt_rdata_r;
    assign msg_ack_out = msg_ack_r;
    assign perf_count_out = perf_r;

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (ctrl_load_in && ctrl_count_in != COUNT_RESET) begin
                    state_nxt = ST_FETCH_REQ;
                end
            end
            ST_FETCH_REQ: begin
                if (tx_take) begin
                    state_nxt = ST_FETCH_WAIT;
                end
            end
            ST_FETCH_WAIT: begin
                if (cpl_valid_in) begin
                    if (word_r != DESC_W_LAST) begin
                        state_nxt = ST_FETCH_REQ;
                    end else if (size_r == COUNT_RESET) begin
                        state_nxt = ST_NEXT;
                    end else begin
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_LOAD: begin
                state_nxt = ST_XFER_REQ;
            end
            ST_XFER_REQ: begin
                if (tx_take) begin
                    if (!to_host) begin
                        state_nxt = ST_XFER_WAIT;
                    end else if (size_r == 16'h0001) begin
                        state_nxt = ST_NEXT;
                    end else begin
                        state_nxt = ST_LOAD;
                    end
                end
            end
            ST_XFER_WAIT: begin
                if (cpl_valid_in) begin
                    state_nxt = (size_r == 16'h0001) ? ST_NEXT : ST_XFER_REQ;
                end
            end
            ST_NEXT: begin
                if (!last_desc) begin
                    state_nxt = ST_FETCH_REQ;
                end else if (cfg_msi_enable_in) begin
                    state_nxt = ST_IRQ;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IRQ: begin
                if (msi_ack_in) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            remain_r <= COUNT_RESET;
            desc_addr_r <= ADDR_RESET;
            word_r <= DESC_W_CTRL;
            dir_r <= 1'b0;
            size_r <= COUNT_RESET;
            src_r <= ADDR_RESET;
            dst_r <= ADDR_RESET;
            wdata_r <= ADDR_RESET;
            done_r <= 1'b0;
            msi_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            if (state_r == ST_IDLE && ctrl_load_in && ctrl_count_in != COUNT_RESET) begin
                remain_r <= ctrl_count_in;
                desc_addr_r <= {ctrl_first_addr_in[31:2], 2'b00};
                word_r <= DESC_W_CTRL;
                done_r <= 1'b0;
            end
            if (cpl_fetch) begin
                word_r <= word_r + 2'h1;
                unique case (word_r)
                    DESC_W_CTRL: begin
                        dir_r <= cpl_data_in[CTRL_DIR_BIT];
                        size_r <= cpl_size;
                    end
                    DESC_W_SRC: src_r <= cpl_data_in;
                    DESC_W_DST: dst_r <= cpl_data_in;
                    DESC_W_LAST: begin
                    end
                endcase
            end
            if (state_r == ST_LOAD) begin
                wdata_r <= mem_r[wr_eng_idx];
            end
            if (eng_word) begin
                size_r <= size_r - 16'h0001;
                src_r <= src_word + WORD_STEP;
                dst_r <= dst_word + WORD_STEP;
            end
            if (state_r == ST_NEXT) begin
                remain_r <= remain_r - 16'h0001;
                desc_addr_r <= desc_addr_r + DESC_STRIDE;
                word_r <= DESC_W_CTRL;
                if (last_desc) begin
                    done_r <= 1'b1;
                    msi_r <= cfg_msi_enable_in;
                end
            end
            if (state_r == ST_IRQ && msi_ack_in) begin
                msi_r <= 1'b0;
            end
        end
    end

    // local memory: read engine port writes last so it wins a same-word clash
    always_ff @(posedge clk_in) begin
        if (tgt_wr) begin
            mem_r[tgt_addr_in] <= tgt_wdata_in;
        end
        if (mem_from_host) begin
            mem_r[rd_eng_idx] <= cpl_data_in;
        end
    end

    // target path: reads, message acknowledge, traffic counter
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tgt_rvalid_r <= 1'b0;
            tgt_rdata_r <= ADDR_RESET;
            msg_ack_r <= 1'b0;
            perf_r <= ADDR_RESET;
        end else begin
            tgt_rvalid_r <= tgt_rd;
            if (tgt_rd) begin
                tgt_rdata_r <= mem_r[tgt_addr_in];
            end
            msg_ack_r <= msg_valid_in;
            perf_r <= perf_r + {31'h00000000, tgt_valid_in} + {31'h00000000, eng_word};
        end
    end
endmodule // descriptor_dma

// *** dv/descriptor_dma_asserts.sv ***
`timescale 1ns/10ps
module dma_asserts (
    input wire logic clk_in, // clock
    input wire logic rst_in, // reset
    input wire logic ctrl_load_in, // load
    input wire logic [15:0] ctrl_count_in, // count
    input wire logic [31:0] ctrl_first_addr_in, // first
    input wire logic busy_out, // busy
    input wire logic tx_valid_out, // valid
    input wire logic tx_write_out, // write
    input wire logic [31:0] tx_addr_out, // addr
    input wire logic tx_digest_out, // digest
    input wire logic tx_ready_in, // ready
    input wire logic tgt_valid_in, // target
    input wire logic tgt_write_in, // target write
    input wire logic tgt_rvalid_out, // target rvalid
    input wire logic msg_valid_in, // message
    input wire logic msg_ack_out, // message ack
    input wire logic msi_req_out, // irq
    input wire logic msi_ack_in // irq ack
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    no_digest_a: assert property (!tx_digest_out) else $error("digest set");
    tx_hold_a: assert property (tx_valid_out && !tx_ready_in |=> tx_valid_out &&
        $stable(tx_addr_out) && $stable(tx_write_out)) else $error("tx request dropped");
    tx_align_a: assert property (tx_valid_out |-> tx_addr_out[1:0] == 2'h0) else $error("unaligned");
    load_fetch_a: assert property (ctrl_load_in && !busy_out && ctrl_count_in != 16'h0 |=>
        busy_out && tx_valid_out && !tx_write_out && tx_addr_out == ($past(ctrl_first_addr_in) & 32'hffff_fffc))
        else $error("first fetch wrong");
    idle_quiet_a: assert property (!busy_out |-> !tx_valid_out && !msi_req_out) else $error("idle active");
    tgt_read_a: assert property (tgt_valid_in && !tgt_write_in |-> ##1 tgt_rvalid_out) else $error("no rvalid");
    msg_ack_a: assert property (msg_valid_in |=> msg_ack_out) else $error("no message ack");
    msi_hold_a: assert property (msi_req_out && !msi_ack_in |=> msi_req_out) else $error("irq dropped");
    cover property (ctrl_load_in && !busy_out);
    cover property ($rose(msi_req_out));
    cover property (tx_valid_out && tx_write_out && !tx_ready_in);
endmodule // dma_asserts

bind descriptor_dma dma_asserts dma_asserts_inst (.clk_in, .rst_in, .ctrl_load_in, .ctrl_count_in,
    .ctrl_first_addr_in, .busy_out, .tx_valid_out, .tx_write_out, .tx_addr_out, .tx_digest_out,
    .tx_ready_in, .tgt_valid_in, .tgt_write_in, .tgt_rvalid_out, .msg_valid_in, .msg_ack_out,
    .msi_req_out, .msi_ack_in);

// *** dv/host_model.sv ***
`timescale 1ns/10ps
module host_model (
    input wire logic clk_in, // clock
    input wire logic slow_in, // accept every other cycle
    input wire logic tx_valid_in, // request
    input wire logic tx_write_in, // write
    input wire logic [31:0] tx_addr_in, // address
    input wire logic [31:0] tx_data_in, // data
    output logic tx_ready_out, // accept
    output logic cpl_valid_out, // completion
    output logic [31:0] cpl_data_out, // completion data
    input wire logic msi_req_in, // irq
    output logic msi_ack_out // irq taken
);
    logic [31:0] mem [0:255];
    logic tog_r = 1'b0;
    int irq_count = 0;
    initial begin
        foreach (mem[i]) mem[i] = 32'h0;
        cpl_valid_out = 1'b0;
        cpl_data_out = 32'h0;
        msi_ack_out = 1'b0;
    end
    assign tx_ready_out = !slow_in || tog_r;
    always @(posedge clk_in) begin
        tog_r <= !tog_r;
        cpl_valid_out <= 1'b0;
        cpl_data_out <= ~cpl_data_out; // idle data line keeps changing
        msi_ack_out <= msi_req_in && !msi_ack_out;
        if (msi_req_in && !msi_ack_out) irq_count <= irq_count + 1;
        if (tx_valid_in && tx_ready_out && tx_write_in) mem[tx_addr_in[9:2]] <= tx_data_in;
        if (tx_valid_in && tx_ready_out && !tx_write_in) begin
            cpl_valid_out <= 1'b1;
            cpl_data_out <= mem[tx_addr_in[9:2]];
        end
    end
endmodule // host_model

// *** dv/descriptor_dma_pcie_endpoint_bench.sv ***
`timescale 1ns/10ps
module descriptor_dma_pcie_endpoint_bench;
    logic clk_in = 1'b0, rst_in = 1'b1, ctrl_load_in = 1'b0, tgt_valid_in = 1'b0, tgt_write_in = 1'b0;
    logic msg_valid_in = 1'b0, cfg_msi_enable_in = 1'b1, slow_in = 1'b0;
    logic [15:0] ctrl_count_in = 16'h0;
    logic [31:0] ctrl_first_addr_in = 32'h0, tgt_wdata_in = 32'h0, q;
    logic [9:0] tgt_addr_in = 10'h0;
    logic busy_out, done_out, tx_valid_out, tx_write_out, tx_digest_out, tx_ready_in, cpl_valid_in;
    logic tgt_rvalid_out, msg_ack_out, msi_req_out, msi_ack_in;
    logic [31:0] tx_addr_out, tx_data_out, cpl_data_in, tgt_rdata_out, perf_count_out;
    int n_mismatch = 0, checked = 0, n;
    descriptor_dma descriptor_dma_inst (.clk_in, .rst_in, .ctrl_load_in, .ctrl_count_in, .ctrl_first_addr_in,
        .busy_out, .done_out, .tx_valid_out, .tx_write_out, .tx_addr_out, .tx_data_out, .tx_digest_out,
        .tx_ready_in, .cpl_valid_in, .cpl_data_in, .tgt_valid_in, .tgt_write_in, .tgt_addr_in, .tgt_wdata_in,
        .tgt_rvalid_out, .tgt_rdata_out, .msg_valid_in, .msg_ack_out, .perf_count_out, .cfg_msi_enable_in,
        .msi_req_out, .msi_ack_in);
    host_model host_model_inst (.clk_in, .slow_in, .tx_valid_in(tx_valid_out), .tx_write_in(tx_write_out),
        .tx_addr_in(tx_addr_out), .tx_data_in(tx_data_out), .tx_ready_out(tx_ready_in),
        .cpl_valid_out(cpl_valid_in), .cpl_data_out(cpl_data_in), .msi_req_in(msi_req_out),
        .msi_ack_out(msi_ack_in));
    initial forever #12.5 clk_in = ~clk_in;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tgt(input logic wr, input logic [9:0] a, input logic [31:0] d);
        @(negedge clk_in);
        {tgt_valid_in, tgt_write_in, tgt_addr_in, tgt_wdata_in} = {1'b1, wr, a, d};
        @(negedge clk_in);
        tgt_valid_in = 1'b0;
        q = tgt_rdata_out;
    endtask
    task automatic desc(input int i, input logic [31:0] c, input logic [31:0] s, input logic [31:0] d);
        host_model_inst.mem[i] = c;
        host_model_inst.mem[i+1] = s;
        host_model_inst.mem[i+2] = d;
    endtask
    task automatic run(input logic [31:0] a, input logic [15:0] c);
        n = host_model_inst.irq_count;
        @(negedge clk_in);
        {ctrl_first_addr_in, ctrl_count_in, ctrl_load_in} = {a, c, 1'b1};
        @(negedge clk_in);
        ctrl_load_in = 1'b0;
        check("done_clr", done_out, 32'h0);
        for (int i = 0; i < 500 && busy_out !== 1'b0; i++) @(negedge clk_in);
        check("idle", busy_out, 32'h0);
        if (busy_out !== 1'b0) end_sim();
        check("done", done_out, 32'h1);
        check("irqs", host_model_inst.irq_count, n + cfg_msi_enable_in);
    endtask
    task automatic t_target();
        logic [31:0] p;
        p = perf_count_out;
        tgt(1'b1, 10'h3ff, 32'hc3c3_0001);
        tgt(1'b0, 10'h3ff, 32'h0);
        check("tgt_rdata", q, 32'hc3c3_0001);
        check("perf", perf_count_out, p + 32'h2);
        @(negedge clk_in);
        msg_valid_in = 1'b1;
        @(negedge clk_in);
        msg_valid_in = 1'b0;
        check("msg_ack", msg_ack_out, 32'h1);
        $display("test target done");
    endtask
    task automatic t_read();
        for (int i = 0; i < 3; i++) host_model_inst.mem[8'h80+i] = 32'ha5a5_0000 + i;
        desc(8'h40, 32'h8, 32'h200, 32'h0);
        desc(8'h44, 32'h4, 32'h208, 32'h10);
        run(32'h102, 16'h2);
        for (int i = 0; i < 3; i++) begin
            tgt(1'b0, 10'((i < 2) ? i : 4), 32'h0);
            check("local", q, 32'ha5a5_0000 + i);
        end
        $display("test read done");
    endtask
    task automatic t_write();
        tgt(1'b1, 10'h2, 32'ha5a5_0002);
        slow_in = 1'b1;
        desc(8'h48, 32'h8000_000c, 32'h0, 32'h300);
        run(32'h120, 16'h1);
        slow_in = 1'b0;
        for (int i = 0; i < 3; i++) check("host", host_model_inst.mem[8'hc0+i], 32'ha5a5_0000 + i);
        $display("test write done");
    endtask
    task automatic t_nomsi();
        logic [31:0] p;
        cfg_msi_enable_in = 1'b0;
        desc(8'h4c, 32'h0, 32'h0, 32'h3f0);
        p = perf_count_out;
        run(32'h130, 16'h1);
        check("msi_req", msi_req_out, 32'h0);
        check("zero_perf", perf_count_out, p);
        @(negedge clk_in);
        {ctrl_count_in, ctrl_load_in} = {16'h0, 1'b1};
        @(negedge clk_in);
        ctrl_load_in = 1'b0;
        check("zero_busy", busy_out, 32'h0);
        check("zero_done", done_out, 32'h1);
        $display("test no interrupt done");
    endtask
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        t_target();
        t_read();
        t_write();
        t_nomsi();
        end_sim();
    end
endmodule // descriptor_dma_pcie_endpoint_bench
